//--- rtl/adap_pkg.sv
/*
  Shared constants and types for the asynchronous DRAM access controller.
  Assumes a single 40 MHz core clock; all pin timing is counted in its cycles.
*/
`default_nettype none

package adap_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Clock and conversions
  localparam int CLK_PERIOD_NS = 25;

  function automatic int cyc_min(int ns);
    int c;
    c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    return (c < 1) ? 1 : c;
  endfunction

  function automatic int cyc_max(int ns);
    int c;
    c = ns / CLK_PERIOD_NS;
    return (c < 1) ? 1 : c;
  endfunction

  function automatic int max2(int a, int b);
    return (a > b) ? a : b;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Device timing, in printed units
  localparam int POWER_UP_PAUSE_US = 200;
  localparam int WAKE_IDLE_MS = 16;
  localparam int INIT_RAS_CYCLES = 8;
  localparam int ROW_ADDR_HOLD_NS = 10;
  localparam int ROW_TO_COLUMN_DELAY_NS = 20;
  localparam int ROW_ACCESS_TIME_NS = 60;
  localparam int COLUMN_ACCESS_TIME_NS = 20;
  localparam int ROW_PULSE_WIDTH_NS = 60;
  localparam int COLUMN_PULSE_NS = 20;
  localparam int ROW_PRECHARGE_INTERVAL_NS = 45;
  localparam int COLUMN_PRECHARGE_INTERVAL_NS = 10;
  localparam int COLUMN_TO_WRITE_DELAY_NS = 20;
  localparam int WRITE_TO_ROW_LEAD_NS = 20;
  localparam int WRITE_TO_COLUMN_LEAD_NS = 20;
  localparam int DATA_HOLD_NS = 15;
  localparam int PAGE_ROW_PULSE_WIDTH_NS = 200000;

  ////////////////////////////////////////////////////////////////////////////
  // Cycle counts
  localparam int POWER_UP_CYC = cyc_min(POWER_UP_PAUSE_US * 1000);
  localparam int WAKE_IDLE_CYC = cyc_max(WAKE_IDLE_MS * 1000000);
  localparam int PAGE_LIMIT_CYC = cyc_max(PAGE_ROW_PULSE_WIDTH_NS);
  localparam int ROW_CYC = max2(cyc_min(ROW_ADDR_HOLD_NS), cyc_min(ROW_TO_COLUMN_DELAY_NS) - 1);
  localparam int COL_CYC = max2(max2(cyc_min(COLUMN_ACCESS_TIME_NS), cyc_min(COLUMN_PULSE_NS)),
    max2(cyc_min(COLUMN_TO_WRITE_DELAY_NS),
    max2(cyc_min(ROW_ACCESS_TIME_NS), cyc_min(ROW_PULSE_WIDTH_NS)) - ROW_CYC - 1));
  localparam int CWD_CYC = cyc_min(COLUMN_TO_WRITE_DELAY_NS);
  localparam int CWL_CYC = max2(max2(cyc_min(WRITE_TO_COLUMN_LEAD_NS), cyc_min(WRITE_TO_ROW_LEAD_NS)),
    cyc_min(DATA_HOLD_NS));
  localparam int RP_CYC = cyc_min(ROW_PRECHARGE_INTERVAL_NS);
  localparam int CP_CYC = cyc_min(COLUMN_PRECHARGE_INTERVAL_NS);
  localparam int RASMIN_CYC = cyc_min(ROW_PULSE_WIDTH_NS);
  localparam int PAGE_MARGIN_CYC = COL_CYC + CWL_CYC + CP_CYC + 3;

  localparam int CNT_W = 4;
  localparam logic [CNT_W-1:0] ROW_LAST = CNT_W'(ROW_CYC - 1);
  localparam logic [CNT_W-1:0] COL_LAST = CNT_W'(COL_CYC - 1);
  localparam logic [CNT_W-1:0] CWL_LAST = CNT_W'(CWL_CYC - 1);
  localparam logic [CNT_W-1:0] RP_LAST = CNT_W'(RP_CYC - 1);
  localparam logic [CNT_W-1:0] RASMIN_LAST = CNT_W'(RASMIN_CYC - 1);
  localparam logic [3:0] WAKE_COUNT = 4'(INIT_RAS_CYCLES);

  ////////////////////////////////////////////////////////////////////////////
  // Widths
  localparam int ADDR_BITS = 11;
  localparam int TIMER_W = 20;

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer states
  typedef enum logic [8:0] {
    ST_PWRUP   = 9'h001,
    ST_WAKE_LO = 9'h002,
    ST_WAKE_HI = 9'h004,
    ST_IDLE    = 9'h008,
    ST_ROW     = 9'h010,
    ST_COLSET  = 9'h020,
    ST_COL     = 9'h040,
    ST_PAGE    = 9'h080,
    ST_PRE     = 9'h100
  } adap_state_type;

endpackage

`default_nettype wire

//--- rtl/adap_timer_if.sv
/*
  Carrier between the sequencer and its countdown timers.
  Assumes the owner pulses load for one enabled cycle.
*/
`default_nettype none

interface adap_timer_if #(parameter int W = adap_pkg::TIMER_W);
  logic ce;
  logic load;
  logic [W-1:0] value;
  logic done;
  modport owner (output ce, output load, output value, input done);
  modport counter (input ce, input load, input value, output done);
endinterface

`default_nettype wire

//--- rtl/adap_timer.sv
/*
  Loadable countdown timer; done is high while the count stands at zero.
  Assumes one clock domain with the sequencer that owns it.
*/
`default_nettype none

module adap_timer #(
  parameter int W = adap_pkg::TIMER_W
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // Owner side
  adap_timer_if.counter tmr
);
  import adap_pkg::*;

  typedef struct packed {
    logic [W-1:0] cnt;
  } adap_timer_state_type;

  adap_timer_state_type s_q;
  adap_timer_state_type s_d;

  if (W < 2) begin : g_chk
    $error("adap_timer: width too small");
  end

  always_comb begin
    s_d = s_q;
    if (tmr.load) begin
      s_d.cnt = tmr.value;
    end else if (s_q.cnt != '0) begin
      s_d.cnt = s_q.cnt - W'(1);
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      s_q <= '0;
    end else if (tmr.ce) begin
      s_q <= s_d;
    end
  end

  assign tmr.done = (s_q.cnt == '0);

endmodule

`default_nettype wire

//--- rtl/adap_ctrl.sv
/*
  Host-side sequencer for an asynchronous multiplexed-address 4M x 1 DRAM:
  power-up pause, wakeup strobes, read, early write, read-write and page mode.
  Assumes pins and the read data input are synchronous to core_clk.
*/
`default_nettype none

// Behaviour
// - After reset hold both strobes high for the power-up pause.
// - Issue eight row strobe cycles before the first access.
// - After the idle limit without row activity, issue eight wakeup row strobes.
// - Shared pins carry row field at row fall, column field at column fall.
// - Row strobe falls first, column strobe follows after the row-to-column delay.
// - For reads, write strobe is high before column strobe falls.
// - Reads keep write strobe high through and after the strobes rise.
// - Row strobe stays high for the row precharge interval.
// - Write strobe low requests a write; early or late by edge order.
// - After write strobe falls both strobes stay low for their lead times.
// - Read-write keeps write strobe high column-to-write delay after column fall.
// - Page mode keeps row low while column strobe selects new columns.
// - Column strobe stays high the column precharge interval; page kinds mix freely.
// - Page length is bounded so the row low time stays within limit.
// - Page mode ends with row rising with or after column rise.
module adap_ctrl #(
  parameter int ADDR_W = adap_pkg::ADDR_BITS,
  parameter int unsigned POWER_UP_CYC = adap_pkg::POWER_UP_CYC,
  parameter int unsigned WAKE_IDLE_CYC = adap_pkg::WAKE_IDLE_CYC,
  parameter int unsigned PAGE_LIMIT_CYC = adap_pkg::PAGE_LIMIT_CYC
) (
  // Clock, reset, enable
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic ce,
  // Request
  input wire logic reqValid,
  input wire logic reqWrite,
  input wire logic reqRmw,
  input wire logic [2*ADDR_W-1:0] reqAddr,
  input wire logic reqData,
  output logic reqReady,
  // Response
  output logic rspValid,
  output logic rspData,
  output logic initDone,
  // Memory pins
  output logic rasN,
  output logic casN,
  output logic wN,
  output logic [ADDR_W-1:0] memAddr,
  output logic memD,
  input wire logic memQ
);
  import adap_pkg::*;

  localparam int PAGE_LOAD = PAGE_LIMIT_CYC - PAGE_MARGIN_CYC;

  if (ADDR_W < 1 || POWER_UP_CYC >= 2**TIMER_W || WAKE_IDLE_CYC >= 2**TIMER_W
      || PAGE_LIMIT_CYC >= 2**TIMER_W || PAGE_LIMIT_CYC <= PAGE_MARGIN_CYC + 1
      || POWER_UP_CYC < 1 || WAKE_IDLE_CYC < 1) begin : g_chk
    $error("adap_ctrl: parameter out of range");
  end

  typedef struct packed {
    adap_state_type state;
    logic [CNT_W-1:0] cnt;
    logic [3:0] wakeLeft;
    logic started;
    logic initDone;
    logic pend;
    logic write;
    logic rmw;
    logic wrDone;
    logic [ADDR_W-1:0] row;
    logic [ADDR_W-1:0] col;
    logic data;
    logic rasN;
    logic casN;
    logic wN;
    logic [ADDR_W-1:0] addr;
    logic dOut;
    logic reqReady;
    logic rspValid;
    logic rspData;
  } adap_ctrl_state_type;

  adap_ctrl_state_type s_q;
  adap_ctrl_state_type s_d;

  ////////////////////////////////////////////////////////////////////////////
  // Timers: idle/power-up pause and row-low limit
  adap_timer_if #(.W(TIMER_W)) idleTmr ();
  adap_timer_if #(.W(TIMER_W)) pageTmr ();
  logic idleLd;
  logic pageLd;
  logic [TIMER_W-1:0] idleVal;
  logic wakeGo;
  logic startGo;
  logic taken;

  assign idleTmr.ce = ce;
  assign idleTmr.load = idleLd;
  assign idleTmr.value = idleVal;
  assign pageTmr.ce = ce;
  assign pageTmr.load = pageLd;
  assign pageTmr.value = TIMER_W'(PAGE_LOAD);

  adap_timer #(.W(TIMER_W)) u_idle (.core_clk(core_clk), .rst_n(rst_n), .tmr(idleTmr));
  adap_timer #(.W(TIMER_W)) u_page (.core_clk(core_clk), .rst_n(rst_n), .tmr(pageTmr));

  assign taken = reqValid && s_q.reqReady;

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer
  always_comb begin
    s_d = s_q;
    idleLd = 1'b0;
    idleVal = TIMER_W'(WAKE_IDLE_CYC);
    pageLd = 1'b0;
    wakeGo = 1'b0;
    startGo = 1'b0;
    s_d.rspValid = 1'b0;
    s_d.reqReady = 1'b0;
    if (taken) begin
      s_d.row = reqAddr[2*ADDR_W-1:ADDR_W];
      s_d.col = reqAddr[ADDR_W-1:0];
      s_d.write = reqWrite | reqRmw;
      s_d.rmw = reqRmw;
      s_d.data = reqData;
    end
    unique case (s_q.state)
      ST_PWRUP: begin
        if (!s_q.started) begin
          idleLd = 1'b1;
          idleVal = TIMER_W'(POWER_UP_CYC);
          s_d.started = 1'b1;
        end else if (idleTmr.done) begin
          wakeGo = 1'b1;
        end
      end
      ST_WAKE_LO: begin
        if (s_q.cnt != '0) begin
          s_d.cnt = s_q.cnt - CNT_W'(1);
        end else begin
          s_d.rasN = 1'b1;
          s_d.cnt = RP_LAST;
          s_d.wakeLeft = s_q.wakeLeft - 4'h1;
          s_d.state = ST_WAKE_HI;
        end
      end
      ST_WAKE_HI: begin
        if (s_q.cnt != '0) begin
          s_d.cnt = s_q.cnt - CNT_W'(1);
        end else if (s_q.wakeLeft != 4'h0) begin
          s_d.rasN = 1'b0;
          s_d.cnt = RASMIN_LAST;
          s_d.state = ST_WAKE_LO;
        end else begin
          s_d.initDone = 1'b1;
          s_d.reqReady = 1'b1;
          idleLd = 1'b1;
          s_d.state = ST_IDLE;
        end
      end
      ST_IDLE: begin
        if (taken) begin
          startGo = 1'b1;
        end else if (idleTmr.done) begin
          wakeGo = 1'b1;
        end else begin
          s_d.reqReady = 1'b1;
        end
      end
      ST_ROW: begin
        if (s_q.cnt != '0) begin
          s_d.cnt = s_q.cnt - CNT_W'(1);
        end else begin
          s_d.addr = s_q.col;
          s_d.state = ST_COLSET;
        end
      end
      ST_COLSET: begin
        s_d.casN = 1'b0;
        s_d.cnt = COL_LAST;
        s_d.wrDone = 1'b0;
        s_d.state = ST_COL;
      end
      ST_COL: begin
        if (s_q.cnt != '0) begin
          s_d.cnt = s_q.cnt - CNT_W'(1);
        end else if (s_q.rmw && !s_q.wrDone) begin
          s_d.rspValid = 1'b1;
          s_d.rspData = memQ;
          s_d.wN = 1'b0;
          s_d.dOut = s_q.data;
          s_d.wrDone = 1'b1;
          s_d.cnt = CWL_LAST;
        end else begin
          s_d.rspValid = !s_q.write;
          s_d.rspData = s_q.write ? s_q.rspData : memQ;
          s_d.casN = 1'b1;
          s_d.wN = 1'b1;
          s_d.reqReady = !pageTmr.done;
          s_d.state = ST_PAGE;
        end
      end
      ST_PAGE: begin
        if (taken && reqAddr[2*ADDR_W-1:ADDR_W] == s_q.row) begin
          s_d.addr = reqAddr[ADDR_W-1:0];
          s_d.wN = !(reqWrite && !reqRmw);
          s_d.dOut = reqData;
          s_d.state = ST_COLSET;
        end else begin
          s_d.pend = taken;
          s_d.rasN = 1'b1;
          s_d.cnt = RP_LAST;
          idleLd = 1'b1;
          s_d.state = ST_PRE;
        end
      end
      ST_PRE: begin
        if (s_q.cnt != '0) begin
          s_d.cnt = s_q.cnt - CNT_W'(1);
        end else if (s_q.pend) begin
          startGo = 1'b1;
        end else begin
          s_d.reqReady = 1'b1;
          s_d.state = ST_IDLE;
        end
      end
      default: begin
        s_d.state = ST_IDLE;
      end
    endcase
    if (wakeGo) begin
      s_d.rasN = 1'b0;
      s_d.cnt = RASMIN_LAST;
      s_d.wakeLeft = WAKE_COUNT;
      s_d.reqReady = 1'b0;
      s_d.state = ST_WAKE_LO;
    end
    if (startGo) begin
      s_d.rasN = 1'b0;
      s_d.addr = s_d.row;
      s_d.wN = !(s_d.write && !s_d.rmw);
      s_d.dOut = s_d.data;
      s_d.cnt = ROW_LAST;
      s_d.pend = 1'b0;
      s_d.reqReady = 1'b0;
      pageLd = 1'b1;
      s_d.state = ST_ROW;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      s_q <= '{state: ST_PWRUP, rasN: 1'b1, casN: 1'b1, wN: 1'b1, default: '0};
    end else if (ce) begin
      s_q <= s_d;
    end
  end

  assign reqReady = s_q.reqReady;
  assign rspValid = s_q.rspValid;
  assign rspData = s_q.rspData;
  assign initDone = s_q.initDone;
  assign rasN = s_q.rasN;
  assign casN = s_q.casN;
  assign wN = s_q.wN;
  assign memAddr = s_q.addr;
  assign memD = s_q.dOut;

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  logic [31:0] ageCnt;
  logic [3:0] rasFalls;
  logic [31:0] rasLowCnt;
  logic rasPrev;

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      ageCnt <= '0;
      rasFalls <= '0;
      rasLowCnt <= '0;
      rasPrev <= 1'b1;
    end else if (ce) begin
      rasPrev <= s_q.rasN;
      if (ageCnt != 32'hFFFF_FFFF) ageCnt <= ageCnt + 32'h0000_0001;
      if (rasPrev && !s_q.rasN && rasFalls != 4'hF) rasFalls <= rasFalls + 4'h1;
      rasLowCnt <= s_q.rasN ? 32'h0000_0000 : rasLowCnt + 32'h0000_0001;
    end
  end

  property p_pwrup;
    @(posedge core_clk) disable iff (!rst_n) (ageCnt < POWER_UP_CYC) |-> (rasN && casN);
  endproperty
  a_pwrup: assert property (p_pwrup) else $error("strobe active during power-up pause");

  property p_init;
    @(posedge core_clk) disable iff (!rst_n) $fell(casN) |-> (rasFalls >= 4'(INIT_RAS_CYCLES));
  endproperty
  a_init: assert property (p_init) else $error("access before eight row strobe cycles");

  property p_order;
    @(posedge core_clk) disable iff (!rst_n) $fell(casN) |-> (!rasN && !$past(rasN));
  endproperty
  a_order: assert property (p_order) else $error("column strobe fell before row strobe");

  property p_rdsetup;
    @(posedge core_clk) disable iff (!rst_n) ($fell(casN) && wN) |-> $past(wN);
  endproperty
  a_rdsetup: assert property (p_rdsetup) else $error("write strobe not high before read column");

  property p_rdhold;
    @(posedge core_clk) disable iff (!rst_n) ($rose(casN) && $past(wN)) |-> wN;
  endproperty
  a_rdhold: assert property (p_rdhold) else $error("write strobe dropped at read end");

  property p_precharge;
    @(posedge core_clk) disable iff (!rst_n) $rose(rasN) |-> rasN [*2];
  endproperty
  a_precharge: assert property (p_precharge) else $error("row precharge too short");

  property p_wlead;
    @(posedge core_clk) disable iff (!rst_n) ($rose(casN) && !$past(wN)) |-> (!rasN && !$past(wN, CWL_CYC));
  endproperty
  a_wlead: assert property (p_wlead) else $error("strobe rose before write lead time");

  property p_cwd;
    @(posedge core_clk) disable iff (!rst_n) ($fell(wN) && !casN) |-> !$past(casN, CWD_CYC);
  endproperty
  a_cwd: assert property (p_cwd) else $error("read-write write came too early");

  property p_cprech;
    @(posedge core_clk) disable iff (!rst_n) ($rose(casN) && !rasN) |=> casN;
  endproperty
  a_cprech: assert property (p_cprech) else $error("column precharge too short");

  property p_pagelim;
    @(posedge core_clk) disable iff (!rst_n) !rasN |-> (rasLowCnt <= PAGE_LIMIT_CYC);
  endproperty
  a_pagelim: assert property (p_pagelim) else $error("row strobe low too long");

  property p_pageend;
    @(posedge core_clk) disable iff (!rst_n) $rose(rasN) |-> (casN && $past(casN));
  endproperty
  a_pageend: assert property (p_pageend) else $error("row strobe rose before column strobe");

endmodule

`default_nettype wire

//--- sim/adap_dram_model.sv
/*
  Behavioural model of the 4M x 1 multiplexed-address DRAM at the controller's pins.
  Assumes pins move only on core clock edges; slowMode answers at the latest legal time.
*/
`default_nettype none

module adap_dram_model (
  // Memory pins
  input wire logic rasN,
  input wire logic casN,
  input wire logic wN,
  input wire logic [adap_pkg::ADDR_BITS-1:0] memAddr,
  input wire logic memD,
  output wire logic memQ,
  // Answer speed
  input wire logic slowMode
);
  timeunit 1ns;
  timeprecision 100ps;
  import adap_pkg::*;

  ////////////////////////////////////////
  // Cell array and latches
  bit mem [bit [21:0]];
  logic [ADDR_BITS-1:0] rowQ = '0;
  logic [21:0] cellQ = '0;
  logic qEn = 1'b0;
  logic qVal = 1'b0;
  logic lastQ = 1'b0;
  logic cellOk = 1'b0;
  realtime rasT = 0;
  realtime casT = 0;
  realtime dueT = 0;

  // Open output shows the inverse of the last driven value
  assign memQ = qEn ? qVal : ~lastQ;

  ////////////////////////////////////////
  // Strobe handling
  always @(negedge rasN) begin
    rasT = $realtime;
    #1;
    rowQ = memAddr;
  end

  always @(negedge casN) begin
    casT = $realtime;
    #1;
    cellOk = (rasN === 1'b0) && (casT - rasT >= ROW_ADDR_HOLD_NS);
    cellQ = {rowQ, memAddr};
    if (cellOk && wN === 1'b0) begin
      mem[cellQ] = memD;
    end else if (cellOk) begin
      dueT = casT + 5;
      if (slowMode) begin
        dueT = casT + COLUMN_ACCESS_TIME_NS;
        if (rasT + ROW_ACCESS_TIME_NS > dueT) begin
          dueT = rasT + ROW_ACCESS_TIME_NS;
        end
      end
      #(dueT - $realtime);
      if (casN === 1'b0 && wN === 1'b1) begin
        qVal = mem.exists(cellQ) ? mem[cellQ] : 1'b0;
        qEn = 1'b1;
      end
    end
  end

  always @(negedge wN) begin
    #1;
    if (casN === 1'b0 && rasN === 1'b0 && cellOk) begin
      mem[cellQ] = memD;
    end
  end

  always @(posedge casN) begin
    if (qEn) begin
      lastQ = qVal;
    end
    qEn = 1'b0;
  end
endmodule

`default_nettype wire

//--- sim/adap_ctrl_tb.sv
/*
  Self-checking bench for the DRAM access controller against the DRAM model.
  Assumes short power-up, wakeup and page limits handed in as parameters.
*/
`default_nettype none

`define CHK(a, b) begin cmpCount++; if ((a) !== (b)) begin errorCnt++; \
  $display("wrong value at %0t ns: got %0h want %0h", $time, (a), (b)); end end

module adap_ctrl_tb;
  timeunit 1ns;
  timeprecision 100ps;
  import adap_pkg::*;

  ////////////////////////////////////////
  // Signals and instances
  localparam int PWR = 20;
  localparam int WAKE = 200;
  localparam int PAGE = 40;
  localparam real TCK = 25.0;
  logic coreClk = 1'b0;
  logic rstN = 1'b0;
  logic ce = 1'b1;
  logic reqValid = 1'b0, reqWrite = 1'b0, reqRmw = 1'b0, reqData = 1'b0, slowMode = 1'b0;
  logic [21:0] reqAddr = '0;
  wire logic reqReady, rspValid, rspData, initDone, rasN, casN, wN, memD, memQ;
  wire logic [10:0] memAddr;
  int errorCnt = 0, cmpCount = 0, rasFalls = 0, casFalls = 0;
  realtime relT = 0, rasFallT = 0, rasRiseT = 0, casRiseT = 0, wFallT = -1000;

  always #12.5 coreClk = ~coreClk;

  adap_ctrl #(.POWER_UP_CYC(PWR), .WAKE_IDLE_CYC(WAKE), .PAGE_LIMIT_CYC(PAGE)) dut (
    .core_clk(coreClk), .rst_n(rstN), .ce(ce), .reqValid(reqValid), .reqWrite(reqWrite),
    .reqRmw(reqRmw), .reqAddr(reqAddr), .reqData(reqData), .reqReady(reqReady),
    .rspValid(rspValid), .rspData(rspData), .initDone(initDone), .rasN(rasN), .casN(casN),
    .wN(wN), .memAddr(memAddr), .memD(memD), .memQ(memQ));

  adap_dram_model partner (.rasN(rasN), .casN(casN), .wN(wN), .memAddr(memAddr), .memD(memD),
    .memQ(memQ), .slowMode(slowMode));

  ////////////////////////////////////////
  // Pin timing monitor
  always @(posedge rstN) begin
    relT = $realtime;
    rasFalls = 0;
    casFalls = 0;
  end
  always @(negedge rasN) begin
    if (rstN && rasFalls == 0) `CHK($realtime - relT >= PWR * TCK, 1'b1)
    if (rstN) `CHK($realtime - rasRiseT >= ROW_PRECHARGE_INTERVAL_NS, 1'b1)
    rasFalls++;
    rasFallT = $realtime;
  end
  always @(posedge rasN) begin
    if (rstN) `CHK($realtime - rasFallT <= PAGE * TCK, 1'b1)
    if (rstN && wFallT >= rasFallT) `CHK($realtime - wFallT >= WRITE_TO_ROW_LEAD_NS, 1'b1)
    rasRiseT = $realtime;
    #1;
    if (rstN) `CHK(casN, 1'b1)
  end
  always @(negedge casN) begin
    casFalls++;
    `CHK(rasN === 1'b0 && $realtime - rasFallT >= ROW_TO_COLUMN_DELAY_NS, 1'b1)
    `CHK($realtime - casRiseT >= COLUMN_PRECHARGE_INTERVAL_NS, 1'b1)
  end
  always @(posedge casN) begin
    if (rstN && wFallT >= casRiseT) `CHK($realtime - wFallT >= WRITE_TO_COLUMN_LEAD_NS, 1'b1)
    casRiseT = $realtime;
  end
  always @(negedge wN) wFallT = $realtime;

  ////////////////////////////////////////
  // Request tasks
  task automatic sendReq(input logic wr, input logic rmw, input logic [21:0] a, input logic d);
    int n;
    n = 0;
    while (reqReady !== 1'b1 && n < 400) begin
      @(negedge coreClk);
      n++;
    end
    if (n >= 400) begin
      errorCnt++;
      $display("wrong value at %0t ns: request never accepted", $time);
    end
    reqValid = 1'b1;
    reqWrite = wr;
    reqRmw = rmw;
    reqAddr = a;
    reqData = d;
    @(negedge coreClk);
    reqValid = 1'b0;
  endtask

  task automatic readBit(input logic [21:0] a, input logic rmw, input logic d, input logic exp);
    int n;
    n = 0;
    sendReq(1'b0, rmw, a, d);
    while (rspValid !== 1'b1 && n < 20) begin
      @(negedge coreClk);
      n++;
    end
    `CHK(rspValid, 1'b1)
    `CHK(rspData, exp)
  endtask

  task automatic waitIdle;
    int n;
    n = 0;
    while (!(reqReady === 1'b1 && rasN === 1'b1) && n < 100) begin
      @(negedge coreClk);
      n++;
    end
  endtask

  ////////////////////////////////////////
  // Scenarios
  task automatic testInit;
    int n;
    n = 0;
    while (initDone !== 1'b1 && n < 400) begin
      @(negedge coreClk);
      n++;
    end
    `CHK(rasFalls, 8)
    `CHK(casFalls, 0)
    waitIdle();
    $display("init test done");
  endtask

  task automatic testBounds;
    logic [21:0] a [5] = '{22'h00_0000, 22'h3F_FFFF, 22'h3F_F800, 22'h00_07FF, 22'h2A_A555};
    for (int i = 0; i < 5; i++) begin
      sendReq(1'b1, 1'b0, a[i], ~i[0]);
      waitIdle();
      `CHK(partner.mem[a[i]], ~i[0])
    end
    for (int i = 4; i >= 0; i--) readBit(a[i], 1'b0, 1'b0, ~i[0]);
    waitIdle();
    $display("address test done");
  endtask

  task automatic testRmw;
    sendReq(1'b1, 1'b0, 22'h12_3456, 1'b1);
    waitIdle();
    readBit(22'h12_3456, 1'b1, 1'b0, 1'b1);
    waitIdle();
    readBit(22'h12_3456, 1'b0, 1'b0, 1'b0);
    waitIdle();
    $display("read-write test done");
  endtask

  task automatic testPage;
    int r0;
    r0 = rasFalls;
    sendReq(1'b1, 1'b0, {11'h123, 11'h000}, 1'b1);
    sendReq(1'b1, 1'b0, {11'h123, 11'h7FF}, 1'b0);
    readBit({11'h123, 11'h000}, 1'b0, 1'b0, 1'b1);
    sendReq(1'b1, 1'b0, {11'h123, 11'h001}, 1'b1);
    readBit({11'h123, 11'h7FF}, 1'b1, 1'b1, 1'b0);
    `CHK(rasFalls - r0, 1)
    sendReq(1'b1, 1'b0, {11'h456, 11'h000}, 1'b0);
    readBit({11'h123, 11'h7FF}, 1'b0, 1'b0, 1'b1);
    readBit({11'h456, 11'h000}, 1'b0, 1'b0, 1'b0);
    readBit({11'h123, 11'h001}, 1'b0, 1'b0, 1'b1);
    waitIdle();
    r0 = rasFalls;
    for (int i = 0; i < 16; i++) sendReq(1'b1, 1'b0, {11'h2AB, 11'(i * 3)}, i[0]);
    waitIdle();
    `CHK(rasFalls - r0 > 1, 1'b1)
    for (int i = 0; i < 16; i++) readBit({11'h2AB, 11'(i * 3)}, 1'b0, 1'b0, i[0]);
    waitIdle();
    $display("page test done");
  endtask

  task automatic testWake;
    int r0;
    int c0;
    r0 = rasFalls;
    c0 = casFalls;
    ce = 1'b0;
    repeat (300) @(negedge coreClk);
    `CHK(rasFalls - r0, 0)
    ce = 1'b1;
    repeat (150) @(negedge coreClk);
    `CHK(rasFalls - r0, 0)
    repeat (150) @(negedge coreClk);
    `CHK(rasFalls - r0, 8)
    `CHK(casFalls - c0, 0)
    $display("wakeup test done");
  endtask

  task automatic testReset;
    sendReq(1'b1, 1'b0, 22'h05_50AA, 1'b1);
    @(negedge coreClk);
    rstN = 1'b0;
    #1;
    `CHK({rasN, casN, wN}, 3'b111)
    `CHK({reqReady, initDone}, 2'b00)
    repeat (5) @(negedge coreClk);
    rstN = 1'b1;
    testInit();
    readBit(22'h3F_FFFF, 1'b0, 1'b0, 1'b0);
    $display("reset test done");
  endtask

  ////////////////////////////////////////
  // Sequence, watchdog and verdict
  task automatic closeOut;
    $display("comparisons %0d, mismatches %0d", cmpCount, errorCnt);
    if (errorCnt == 0 && cmpCount > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  initial begin
    #(30000 * TCK);
    errorCnt++;
    $display("wrong value at %0t ns: watchdog expired", $time);
    closeOut();
  end

  initial begin
    repeat (5) @(negedge coreClk);
    rstN = 1'b1;
    testInit();
    testBounds();
    slowMode = 1'b1;
    testRmw();
    testPage();
    testWake();
    testReset();
    closeOut();
  end
endmodule

`default_nettype wire
